// ===== src/dmm_pkg.sv
// Shared constants, types and carriers for the DAC mode/mute front end
package dmm_pkg;

    // Register map and field layout of the mode control register
    localparam logic [7:0] MODE_CTL_IDX = 8'h01;
    localparam int CAL_BIT = 7;
    localparam int MUTE_BIT = 6;
    localparam int MODE_HI = 5;
    localparam int MODE_LO = 1;
    localparam int PWR_DOWN_BIT = 0;
    localparam logic [7:0] MODE_CTL_RST = 8'h01;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Speed codes held in the upper three mode bits
    localparam logic [2:0] SPD_CODE_DOUBLE = 3'h7;
    localparam logic [2:0] SPD_CODE_QUAD = 3'h6;

    // Ramp lengths in frame clock periods
    localparam logic [12:0] RAMP_SINGLE = 13'h0480;
    localparam logic [12:0] RAMP_DOUBLE = 13'h0900;
    localparam logic [12:0] RAMP_QUAD = 13'h1200;
    localparam logic [12:0] RAMP_CNT_RST = 13'h0000;

    // Serial receiver sizes and counts
    localparam int SAMPLE_W = 24;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3F;
    localparam logic [5:0] BIT_CNT_RST = 6'h00;
    localparam logic [5:0] I2S_DELAY = 6'h01;
    localparam logic [5:0] NO_DELAY = 6'h00;
    localparam logic [5:0] WORD_BITS = 6'h18;

    // Speed modes
    typedef enum logic [1:0] {
        SPD_SINGLE = 2'b00,
        SPD_DOUBLE = 2'b01,
        SPD_QUAD = 2'b10
    } dmm_speed_type;

    // Serial audio formats
    typedef enum logic [1:0] {
        FMT_LJ = 2'b00,
        FMT_I2S = 2'b01,
        FMT_RJ16 = 2'b10,
        FMT_RJ24 = 2'b11
    } dmm_format_type;

    // De-emphasis selections
    typedef enum logic [1:0] {
        DEM_32K = 2'b00,
        DEM_44K1 = 2'b01,
        DEM_48K = 2'b10,
        DEM_OFF = 2'b11
    } dmm_deemph_type;

    // Soft mute sequencer states
    typedef enum logic [1:0] {
        MUT_OPEN = 2'b00,
        MUT_RAMP_DN = 2'b01,
        MUT_SHUT = 2'b10,
        MUT_RAMP_UP = 2'b11
    } dmm_mute_state_type;

    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmm_reg_req_type;

    // Stereo sample pair
    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } dmm_pair_type;

    // Decoded operating mode
    typedef struct packed {
        dmm_format_type format;
        dmm_deemph_type deemph;
        logic deemph_en;
        dmm_speed_type speed;
    } dmm_mode_type;

endpackage

// ===== src/dmm_ctrl.sv
// DAC mode control register, soft mute sequencer and serial audio input
// Summary of operation
// - Register 01h: cal, mute, mode, power down
// - Host reads and writes the mode register
// - Writing cal starts calibration, self-clears when done
// - Mute bit active low, resets to mute
// - Ramp lasts 1152/2304/4608 frames by speed
// - Indicator low only after ramp down completes, after reset, or while powered down
// - Release raises indicator at once, then ramps
// - Mode field resets to zero, picks format
// - De-emphasis tuned for 32, 44.1, 48 kHz
// - Power down resets to one, host clears
// - Reset low returns all state and registers to their reset values
// - Left-right pairs output together
// - Samples twos complement, MSB first
// - Framing follows register or mode pins
// - Mute pin active low, high releases indicator
// - Speed modes cover 16-50, 50-100, 100-200 kHz
// - Config select low picks hardware mode
// - Config select high uses register mode field
// - Low mode bits choose four formats
// - Middle mode bits choose de-emphasis
// - Upper bits 111 double, 110 quad speed
`timescale 1ns/100ps
module dmm_ctrl (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Serial audio link, bit clock domain
    input wire logic bit_clk,
    input wire logic frame_channel_clock,
    input wire logic serial_audio_in,
    // Control port register access
    input wire dmm_pkg::dmm_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    // Configuration pins
    input wire logic cfg_sel,
    input wire logic soft_mute_n,
    input wire logic [4:0] mode_pins,
    // Analog calibration handshake
    input wire logic cal_done,
    output logic cal_active,
    // Mute and power status
    output logic mute_indicator,
    output logic power_down,
    output logic bias_hold,
    output logic [12:0] ramp_count,
    output dmm_pkg::dmm_mute_state_type mute_state,
    // Decoded mode and received samples
    output dmm_pkg::dmm_mode_type mode_cfg,
    output dmm_pkg::dmm_pair_type audio_pair,
    output logic pair_strobe
);
    import dmm_pkg::*;

    // Register state
    logic [7:0] mode_ctl;
    // Pin synchronisers, two stages each
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    wire cp_mode = pin_s2[6];
    wire mute_pin_n = pin_s2[5];
    wire [4:0] mode_pins_s = pin_s2[4:0];

    // Register decode
    wire hit = reg_req.addr == MODE_CTL_IDX;
    wire wr_hit = reg_req.wr && hit;
    wire rd_hit = reg_req.rd && hit;
    wire cal_start = wr_hit && reg_req.wdata[CAL_BIT];
    wire cal_bit = mode_ctl[CAL_BIT];
    wire [4:0] mode_reg = mode_ctl[MODE_HI:MODE_LO];

    // Effective mode source and mute request
    wire [4:0] mode_eff = cp_mode ? mode_reg : mode_pins_s;
    wire mute_req = cp_mode ? ~mode_ctl[MUTE_BIT] : ~mute_pin_n;
    wire pd_eff = cp_mode & mode_ctl[PWR_DOWN_BIT];

    // Mode decode
    wire [2:0] spd_code = mode_eff[4:2];
    wire is_double = spd_code == SPD_CODE_DOUBLE;
    wire is_quad = spd_code == SPD_CODE_QUAD;
    wire dmm_speed_type next_speed = is_double ? SPD_DOUBLE :
        (is_quad ? SPD_QUAD : SPD_SINGLE);
    wire dmm_format_type next_format = dmm_format_type'(mode_eff[1:0]);
    wire dmm_deemph_type next_deemph = mode_eff[4] ? DEM_OFF :
        dmm_deemph_type'(mode_eff[3:2]);
    wire next_deemph_en = next_deemph != DEM_OFF;
    wire [12:0] ramp_len = is_double ? RAMP_DOUBLE :
        (is_quad ? RAMP_QUAD : RAMP_SINGLE);

    // Pin synchroniser flip-flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1 <= 7'h00;
            pin_s2 <= 7'h00;
        end else begin
            pin_s1 <= {cfg_sel, soft_mute_n, mode_pins};
            pin_s2 <= pin_s1;
        end
    end

    // Mode control register; calibration start wins over completion
    wire next_cal = cal_start | (cal_bit & ~cal_done);
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_ctl <= MODE_CTL_RST;
        end else if (wr_hit) begin
            mode_ctl <= {next_cal, reg_req.wdata[6:0]};
        end else begin
            mode_ctl <= {next_cal, mode_ctl[6:0]};
        end
    end

    // Read data register; unmapped reads return zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= UNMAPPED_READ;
        end else if (reg_req.rd) begin
            reg_rdata <= rd_hit ? mode_ctl : UNMAPPED_READ;
        end
    end

    // Registered mode outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_cfg <= '{FMT_LJ, DEM_32K, 1'b1, SPD_SINGLE};
            power_down <= 1'b1;
            cal_active <= 1'b0;
        end else begin
            mode_cfg <= '{next_format, next_deemph, next_deemph_en,
                next_speed};
            power_down <= pd_eff;
            cal_active <= cal_bit;
        end
    end

    // ---------------- Bit clock domain receiver ----------------
    // Format bits cross as quasi-static levels
    // A format change lands two bit clocks late; the first word may be lost
    logic [1:0] fmt_s1;
    logic [1:0] fmt_s2;
    logic lr_prev;
    logic [5:0] bit_cnt;
    logic [SAMPLE_W-1:0] shreg;
    logic [SAMPLE_W-1:0] acc;
    logic [SAMPLE_W-1:0] held_left;
    dmm_pair_type link_pair;
    logic pair_tgl;

    // Channel edge and bit position of the current bit
    wire lr_chg = frame_channel_clock != lr_prev;
    wire [5:0] cur_cnt = lr_chg ? BIT_CNT_RST :
        ((bit_cnt == BIT_CNT_MAX) ? bit_cnt : bit_cnt + 6'h01);
    wire [5:0] bit_off = (fmt_s2 == FMT_I2S) ? I2S_DELAY : NO_DELAY;
    wire [5:0] pos = cur_cnt - bit_off;
    wire in_word = (cur_cnt >= bit_off) && (pos < WORD_BITS);
    wire [4:0] acc_idx = 5'(WORD_BITS - 6'h01 - pos);
    // I2S carries left while frame clock is low, others while high
    wire prev_is_left = (fmt_s2 == FMT_I2S) ? ~lr_prev : lr_prev;
    // Word just finished, aligned MSB first as twos complement
    wire [SAMPLE_W-1:0] rj16_word = {shreg[15:0], 8'h00};
    wire [SAMPLE_W-1:0] done_word = (fmt_s2 == FMT_RJ16) ? rj16_word :
        ((fmt_s2 == FMT_RJ24) ? shreg : acc);

    // Left-justified accumulator next value
    logic [SAMPLE_W-1:0] next_acc;
    always_comb begin
        next_acc = lr_chg ? '0 : acc;
        if (in_word) begin
            next_acc[acc_idx] = serial_audio_in;
        end
    end

    // Serial shift and position tracking
    always_ff @(posedge bit_clk or negedge nrst) begin
        if (!nrst) begin
            fmt_s1 <= 2'h0;
            fmt_s2 <= 2'h0;
            lr_prev <= 1'b0;
            bit_cnt <= BIT_CNT_RST;
            shreg <= '0;
            acc <= '0;
        end else begin
            fmt_s1 <= mode_cfg.format;
            fmt_s2 <= fmt_s1;
            lr_prev <= frame_channel_clock;
            bit_cnt <= cur_cnt;
            shreg <= {shreg[SAMPLE_W-2:0], serial_audio_in};
            acc <= next_acc;
        end
    end

    // Pairing: a left word waits for its right partner
    always_ff @(posedge bit_clk or negedge nrst) begin
        if (!nrst) begin
            held_left <= '0;
            link_pair <= '0;
            pair_tgl <= 1'b0;
        end else if (lr_chg && prev_is_left) begin
            held_left <= done_word;
        end else if (lr_chg) begin
            link_pair <= '{held_left, done_word};
            pair_tgl <= ~pair_tgl;
        end
    end

    // ---------------- Core domain pair capture ----------------
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    wire frame_evt = tgl_s2 ^ tgl_s3;

    // Toggle crossing; pair data is stable while the toggle settles
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
            audio_pair <= '0;
            pair_strobe <= 1'b0;
        end else begin
            tgl_s1 <= pair_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
            pair_strobe <= frame_evt;
            if (frame_evt) begin
                audio_pair <= link_pair;
            end
        end
    end

    // ---------------- Soft mute sequencer ----------------
    dmm_mute_state_type next_state;
    logic [12:0] next_cnt;
    // Ramp ends on the frame that completes the count
    wire ramp_end = ramp_count >= ramp_len - 13'h0001;

    // Next state: each frame advances the ramp, a new request restarts
    always_comb begin
        next_state = mute_state;
        next_cnt = ramp_count;
        unique case (mute_state)
            MUT_OPEN: begin
                if (mute_req) begin
                    next_state = MUT_RAMP_DN;
                    next_cnt = RAMP_CNT_RST;
                end
            end
            MUT_RAMP_DN: begin
                if (!mute_req) begin
                    next_state = MUT_RAMP_UP;
                    next_cnt = RAMP_CNT_RST;
                end else if (frame_evt && ramp_end) begin
                    next_state = MUT_SHUT;
                end else if (frame_evt) begin
                    next_cnt = ramp_count + 13'h0001;
                end
            end
            MUT_SHUT: begin
                if (!mute_req) begin
                    next_state = MUT_RAMP_UP;
                    next_cnt = RAMP_CNT_RST;
                end
            end
            MUT_RAMP_UP: begin
                if (mute_req) begin
                    next_state = MUT_RAMP_DN;
                    next_cnt = RAMP_CNT_RST;
                end else if (frame_evt && ramp_end) begin
                    next_state = MUT_OPEN;
                end else if (frame_evt) begin
                    next_cnt = ramp_count + 13'h0001;
                end
            end
        endcase
    end

    // Sequencer registers; indicator low only when fully muted or powered down
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mute_state <= MUT_SHUT;
            ramp_count <= RAMP_CNT_RST;
            mute_indicator <= 1'b0;
            bias_hold <= 1'b1;
        end else begin
            mute_state <= next_state;
            ramp_count <= next_cnt;
            mute_indicator <= (next_state != MUT_SHUT) & ~pd_eff;
            bias_hold <= next_state == MUT_SHUT;
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_REG_WRITE: assert property (
        wr_hit |=> mode_ctl[6:0] == $past(reg_req.wdata[6:0]))
        else $error("mode register write not stored");
    AST_CAL_SET: assert property (
        cal_start |=> cal_bit ##1 cal_active)
        else $error("calibration start lost");
    AST_CAL_CLEAR: assert property (
        cal_bit && cal_done && !cal_start |=> !cal_bit)
        else $error("calibration bit not cleared on completion");
    AST_CAL_HOLD: assert property (
        cal_bit && !cal_done |=> cal_bit)
        else $error("calibration bit dropped early");
    AST_RELEASE_FAST: assert property (
        mute_state == MUT_SHUT && !mute_req && !pd_eff
        |=> mute_state == MUT_RAMP_UP && mute_indicator)
        else $error("indicator not raised on release");
    AST_LOW_ONLY_MUTED: assert property (
        !mute_indicator |-> mute_state == MUT_SHUT || $past(pd_eff))
        else $error("indicator low before ramp complete");
    AST_RAMP_DONE: assert property (
        mute_state == MUT_RAMP_DN && mute_req && frame_evt
        && ramp_count == ramp_len - 13'h0001
        |=> mute_state == MUT_SHUT && !mute_indicator)
        else $error("ramp down did not end at its length");
    AST_RAMP_RESTART: assert property (
        mute_state == MUT_RAMP_UP && mute_req
        |=> mute_state == MUT_RAMP_DN && ramp_count == RAMP_CNT_RST)
        else $error("ramp not restarted on new request");
    AST_SPEED: assert property (
        mode_eff[4:2] == SPD_CODE_QUAD |=> mode_cfg.speed == SPD_QUAD)
        else $error("quad speed not decoded");
    AST_HW_SOURCE: assert property (
        !cp_mode |=> !power_down
        && mode_cfg.format == $past(mode_pins_s[1:0]))
        else $error("hardware mode not following pins");
    AST_PWR_DOWN: assert property (
        cp_mode && mode_ctl[PWR_DOWN_BIT]
        |=> power_down && !mute_indicator)
        else $error("power down not applied");
    AST_PAIR_CAPTURE: assert property (
        frame_evt |=> pair_strobe && audio_pair == $past(link_pair))
        else $error("received pair not captured");

endmodule

// ===== test/dmm_src_model.sv
// Behavioural digital audio source driving the serial audio input
`timescale 1ns/100ps
module dmm_src_model (
    // Serial audio link toward the converter
    output logic bit_clk,
    output logic frame_channel_clock,
    output logic serial_audio_in
);
    import dmm_pkg::*;
    // Link clock stands still low outside frames
    initial begin
        bit_clk = 1'b0;
        frame_channel_clock = 1'b0;
        serial_audio_in = 1'b0;
    end

    // One frame of two 32-bit slots in the given format, 12 ns bit period
    // Every frame is 64 bit clocks, a steady rate from one source
    task automatic send_pair(input logic [23:0] l, input logic [23:0] r,
        input dmm_format_type fmt);
        logic [23:0] w;
        int s;
        int n;
        int j;
        // First slot bit of the word and its length
        s = (fmt == FMT_LJ) ? 0 : (fmt == FMT_I2S) ? 1 :
            (fmt == FMT_RJ16) ? 16 : 8;
        n = (fmt == FMT_RJ16) ? 16 : 24;
        for (int i = 0; i < 64; i++) begin
            w = (i < 32) ? l : r;
            j = i % 32 - s;
            // I2S carries left while the frame clock is low
            frame_channel_clock = (i < 32) ^ (fmt == FMT_I2S);
            serial_audio_in = (j >= 0 && j < n) ? w[23 - j] : 1'b0;
            #6 bit_clk = 1'b1;
            #6 bit_clk = 1'b0;
        end
        // Released data line shows the inverse of the last bit
        serial_audio_in = ~serial_audio_in;
    endtask
endmodule

// ===== test/tb_top.sv
// Self-checking testbench for the DAC mode and mute front end
`timescale 1ns/100ps
module tb_top;
    import dmm_pkg::*;
    // Stimulus and observed signals
    logic core_clk = 1'b0, nrst = 1'b0, cfg_sel = 1'b1;
    logic soft_mute_n = 1'b0, cal_done = 1'b0;
    logic [4:0] mode_pins = 5'h00;
    dmm_reg_req_type reg_req = '0;
    logic bit_clk, fcc, sdi, cal_active, mute_indicator, power_down;
    logic bias_hold, pair_strobe;
    logic [7:0] reg_rdata;
    logic [12:0] ramp_count;
    dmm_mute_state_type mute_state;
    dmm_mode_type mode_cfg;
    dmm_pair_type audio_pair, last_pair, exp_pair;
    int n_fail = 0, compares = 0, n_strobe = 0, base = 0;
    logic [4:0] m;

    always #10 core_clk = ~core_clk;

    dmm_src_model src (.bit_clk(bit_clk), .frame_channel_clock(fcc),
        .serial_audio_in(sdi));

    dmm_ctrl DUT (.core_clk(core_clk), .nrst(nrst), .bit_clk(bit_clk),
        .frame_channel_clock(fcc), .serial_audio_in(sdi),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .cfg_sel(cfg_sel),
        .soft_mute_n(soft_mute_n), .mode_pins(mode_pins),
        .cal_done(cal_done), .cal_active(cal_active),
        .mute_indicator(mute_indicator), .power_down(power_down),
        .bias_hold(bias_hold), .ramp_count(ramp_count),
        .mute_state(mute_state), .mode_cfg(mode_cfg),
        .audio_pair(audio_pair), .pair_strobe(pair_strobe));

    // Capture every received pair and count them
    always @(posedge core_clk) begin
        if (pair_strobe === 1'b1) begin
            last_pair <= audio_pair;
            n_strobe <= n_strobe + 1;
        end
    end

    // Ends the run with the counts and the verdict
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Compare one value and report a mismatch
    task automatic chk(input string nm, input logic [47:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Register write: one-cycle strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk) #1;
        reg_req.wr = 1'b0;
    endtask

    // Register read: data valid one cycle after the taking edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk) #1;
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk) #1;
        reg_req.rd = 1'b0;
        @(posedge core_clk) #1;
        chk("reg_rdata", e, reg_rdata);
    endtask

    // Bounded wait for the mute indicator level
    task automatic wait_ind(input logic v);
        for (int i = 0; i < 10 && mute_indicator !== v; i++)
            @(posedge core_clk) #1;
        chk("mute_indicator", v, mute_indicator);
        if (mute_indicator !== v)
            print_verdict;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge core_clk);
        rd_chk(MODE_CTL_IDX, MODE_CTL_RST);
        chk("mute_indicator", 0, mute_indicator);
        chk("power_down", 1, power_down);
        chk("mute_state", MUT_SHUT, mute_state);
        rd_chk(8'h02, UNMAPPED_READ);
        wr_reg(8'h00, 8'hFF);
        rd_chk(MODE_CTL_IDX, MODE_CTL_RST);
        $display("test reset_map done");
        wr_reg(MODE_CTL_IDX, 8'h40);
        wait_ind(1'b1);
        chk("power_down", 0, power_down);
        rd_chk(MODE_CTL_IDX, 8'h40);
        wr_reg(MODE_CTL_IDX, 8'hC0);
        rd_chk(MODE_CTL_IDX, 8'hC0);
        chk("cal_active", 1, cal_active);
        repeat (5) @(posedge core_clk);
        rd_chk(MODE_CTL_IDX, 8'hC0);
        @(posedge core_clk) #1 cal_done = 1'b1;
        @(posedge core_clk) #1 cal_done = 1'b0;
        rd_chk(MODE_CTL_IDX, 8'h40);
        $display("test release_cal done");
        // Every mode code decoded into speed and format, de-emphasis where bit 4 is low
        for (int k = 0; k < 32; k++) begin
            m = k[4:0];
            wr_reg(MODE_CTL_IDX, {2'b01, m, 1'b0});
            repeat (3) @(posedge core_clk);
            #1;
            chk("speed", m[4:2] == 3'h7 ? SPD_DOUBLE : m[4:2] == 3'h6 ?
                SPD_QUAD : SPD_SINGLE, mode_cfg.speed);
            chk("format", m[1:0], mode_cfg.format);
            if (!m[4]) begin
                chk("deemph", m[3:2], mode_cfg.deemph);
                chk("deemph_en", m[3:2] != 2'b11, mode_cfg.deemph_en);
            end
        end
        $display("test mode_decode done");
        // Every serial format: priming pair, data pair, flushing pair
        for (int f = 0; f < 4; f++) begin
            wr_reg(MODE_CTL_IDX, {5'b01000, f[1:0], 1'b0});
            repeat (3) @(posedge core_clk);
            src.send_pair(24'h000000, 24'h000000, dmm_format_type'(f[1:0]));
            src.send_pair(24'h812345, 24'h7EDCBA, dmm_format_type'(f[1:0]));
            src.send_pair(24'h000000, 24'h000000, dmm_format_type'(f[1:0]));
            repeat (4) @(posedge core_clk);
            #1;
            // Short right justified words sit in the top 16 bits
            exp_pair = (f == 2) ? {24'h812300, 24'h7EDC00} :
                {24'h812345, 24'h7EDCBA};
            chk("audio_pair", exp_pair, last_pair);
        end
        $display("test audio_in done");
        // Mute request part-way through the release ramp
        wr_reg(MODE_CTL_IDX, 8'h00);
        repeat (3) @(posedge core_clk);
        #1;
        chk("mute_state", MUT_RAMP_DN, mute_state);
        chk("ramp_count", 0, ramp_count);
        base = n_strobe;
        for (int i = 0; i < 1300 && n_strobe - base < 1151; i++)
            src.send_pair(i[23:0], ~i[23:0], FMT_LJ);
        chk("frames", 1151, n_strobe - base);
        chk("mute_indicator", 1, mute_indicator);
        src.send_pair(24'h000000, 24'h000000, FMT_LJ);
        repeat (3) @(posedge core_clk);
        #1;
        chk("mute_indicator", 0, mute_indicator);
        chk("bias_hold", 1, bias_hold);
        chk("mute_state", MUT_SHUT, mute_state);
        $display("test mute_ramp done");
        // Pin-strapped configuration
        cfg_sel = 1'b0;
        mode_pins = 5'h1D;
        soft_mute_n = 1'b1;
        wait_ind(1'b1);
        chk("speed", SPD_DOUBLE, mode_cfg.speed);
        chk("format", FMT_I2S, mode_cfg.format);
        $display("test hw_mode done");
        @(posedge core_clk) #1 nrst = 1'b0;
        repeat (3) @(posedge core_clk);
        chk("mute_indicator", 0, mute_indicator);
        #1 nrst = 1'b1;
        rd_chk(MODE_CTL_IDX, MODE_CTL_RST);
        $display("test mid_reset done");
        print_verdict;
    end

    // Overall guard against a hang
    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        print_verdict;
    end
endmodule
